// *** rtl/slr_pkg.sv ***
// Constants and carrier types for the serial link parameter and status register bank.
// Assumes a classic Wishbone register port on a 125 MHz clock with synchronous reset.
// Overview of operation
// - Programmed 8-bit device identifier goes out in second alignment multiframe.
// - End character select: 0 K28.7 default, 1 K28.1, 2 K28.5, 3 reserved.
// - Selected end character inserted opportunistically, only in 8B/10B encoding modes.
// - Status bit 6 reads one while the serial link is up.
// - Status bit 5 is zero while sync request asserted, one otherwise.
// - Status bit 4 sets when SYSREF shifts a clock phase; write one clears.
// - Status bit 3 sets on first SYSREF after serial link enable; write one clears.
// - Status bit 2 is high while the serializer PLL is locked.
// - Status bit 0 is high while the converter sampling PLL is locked.
// - Identifier, end character and status registers reset to zero.
package slr_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] DEV_ID_IDX = 12'h206;
    localparam logic [11:0] END_CHAR_IDX = 12'h207;
    localparam logic [11:0] STATUS_IDX = 12'h208;
    localparam logic [11:0] IRQ_MASK_IDX = 12'h20A;
    localparam logic [11:0] CTRL_IDX = 12'h20B;
    localparam logic [7:0] DEV_ID_RST = 8'h00;
    localparam logic [7:0] END_CHAR_RST = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] IRQ_MASK_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam int ST_LINK_UP = 6;
    localparam int ST_SYNC = 5;
    localparam int ST_REALIGNED = 4;
    localparam int ST_PHASE_SET = 3;
    localparam int ST_SPLL = 2;
    localparam int ST_CPLL = 0;
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_ENC_8B10B = 1;
    localparam logic [7:0] K28_7 = 8'hFC;
    localparam logic [7:0] K28_1 = 8'h3C;
    localparam logic [7:0] K28_5 = 8'hBC;

    typedef enum logic [1:0] {
        SLR_EOF_K28_7 = 2'b00,
        SLR_EOF_K28_1 = 2'b01,
        SLR_EOF_K28_5 = 2'b10,
        SLR_EOF_RSVD = 2'b11
    } slr_eof_e;

    typedef struct packed {
        logic link_up;
        logic sync_req_n;
        logic sysref_shift;
        logic sysref_event;
        logic serializer_pll_lock;
        logic converter_pll_lock;
    } slr_link_in_s;

    typedef struct packed {
        logic serial_link_enable;
        logic enc_8b10b;
        logic [7:0] device_id;
        logic eof_char_valid;
        logic [7:0] eof_char;
    } slr_link_out_s;
endpackage

// *** rtl/slr_regs.sv ***
// Register bank for the serial link device identifier, end character and link status.
// Assumes a classic Wishbone master, byte addressed with the register index in bits 13:2, all inputs synchronous.
`timescale 1ns/1ps
`default_nettype none
module slr_regs (
    input wire logic clk_i,                          // 125 MHz clock
    input wire logic rst_i,                          // Synchronous reset, active high
    input wire logic wb_cyc_i,                       // Wishbone cycle
    input wire logic wb_stb_i,                       // Wishbone strobe
    input wire logic wb_we_i,                        // Write enable
    input wire logic [13:0] wb_adr_i,                // Byte address
    input wire logic [3:0] wb_sel_i,                 // Byte selects
    input wire logic [31:0] wb_dat_i,                // Write data
    output logic [31:0] wb_dat_o,                    // Read data
    output logic wb_ack_o,                           // Acknowledge
    input wire slr_pkg::slr_link_in_s link_i,        // Link status inputs
    output slr_pkg::slr_link_out_s link_o,           // Link parameters to framer
    output logic irq_o                               // Level interrupt
);
    logic [7:0] dev_id_reg;
    logic [7:0] end_char_reg;
    logic [7:0] status_reg;
    logic [7:0] mask_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] status_next;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic enable_d_reg;
    logic phase_armed_reg;
    logic irq_reg;
    slr_pkg::slr_link_out_s link_reg;
    logic req;
    logic wr;
    logic [11:0] idx;

    function automatic logic [7:0] eof_code(input logic [1:0] sel);
        case (sel)
            2'b01: eof_code = slr_pkg::K28_1;
            2'b10: eof_code = slr_pkg::K28_5;
            default: eof_code = slr_pkg::K28_7;
        endcase
    endfunction

    assign req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign idx = wb_adr_i[13:2];

    // One wait state: ack one edge after request seen, dropped the next cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_reg <= 1'b0;
        else
            ack_reg <= req;
    end

    // Software may write these at any time; it keeps them steady while enabled
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dev_id_reg <= slr_pkg::DEV_ID_RST;
            end_char_reg <= slr_pkg::END_CHAR_RST;
            mask_reg <= slr_pkg::IRQ_MASK_RST;
            ctrl_reg <= slr_pkg::CTRL_RST;
        end
        else if (wr)
        begin
            if (idx == slr_pkg::DEV_ID_IDX)
                dev_id_reg <= wb_dat_i[7:0];
            else if (idx == slr_pkg::END_CHAR_IDX)
                end_char_reg <= wb_dat_i[7:0];
            else if (idx == slr_pkg::IRQ_MASK_IDX)
                mask_reg <= wb_dat_i[7:0];
            else if (idx == slr_pkg::CTRL_IDX)
                ctrl_reg <= wb_dat_i[7:0];
        end
    end

    // First SYSREF after an enable rising edge marks the multiframe phase
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            enable_d_reg <= 1'b0;
            phase_armed_reg <= 1'b0;
        end
        else
        begin
            enable_d_reg <= ctrl_reg[slr_pkg::CTRL_ENABLE];
            if (!ctrl_reg[slr_pkg::CTRL_ENABLE])
                phase_armed_reg <= 1'b0;
            // An event in the enable cycle itself already counts as the first one
            else if (!enable_d_reg)
                phase_armed_reg <= !link_i.sysref_event;
            else if (link_i.sysref_event)
                phase_armed_reg <= 1'b0;
        end
    end

    always_comb
    begin
        status_next = status_reg;
        // Write-one clears; zeros and writes to live bits have no effect
        if (wr && idx == slr_pkg::STATUS_IDX)
        begin
            status_next[slr_pkg::ST_REALIGNED] = status_reg[slr_pkg::ST_REALIGNED]
                && !wb_dat_i[slr_pkg::ST_REALIGNED];
            status_next[slr_pkg::ST_PHASE_SET] = status_reg[slr_pkg::ST_PHASE_SET]
                && !wb_dat_i[slr_pkg::ST_PHASE_SET];
        end
        // Set beats a same-cycle clear
        if (link_i.sysref_shift)
            status_next[slr_pkg::ST_REALIGNED] = 1'b1;
        if (link_i.sysref_event && ctrl_reg[slr_pkg::CTRL_ENABLE]
            && (phase_armed_reg || !enable_d_reg))
            status_next[slr_pkg::ST_PHASE_SET] = 1'b1;
        status_next[slr_pkg::ST_LINK_UP] = link_i.link_up;
        status_next[slr_pkg::ST_SYNC] = link_i.sync_req_n;
        status_next[slr_pkg::ST_SPLL] = link_i.serializer_pll_lock;
        status_next[slr_pkg::ST_CPLL] = link_i.converter_pll_lock;
        status_next[7] = 1'b0;
        status_next[1] = 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            status_reg <= slr_pkg::STATUS_RST;
        else
            status_reg <= status_next;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_reg <= 1'b0;
        else
            irq_reg <= |(status_next & mask_reg);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdata_reg <= 32'h0000_0000;
        else if (req && !wb_we_i)
        begin
            if (idx == slr_pkg::DEV_ID_IDX)
                rdata_reg <= {24'h00_0000, dev_id_reg};
            else if (idx == slr_pkg::END_CHAR_IDX)
                rdata_reg <= {24'h00_0000, end_char_reg};
            else if (idx == slr_pkg::STATUS_IDX)
                rdata_reg <= {24'h00_0000, status_reg};
            else if (idx == slr_pkg::IRQ_MASK_IDX)
                rdata_reg <= {24'h00_0000, mask_reg};
            else if (idx == slr_pkg::CTRL_IDX)
                rdata_reg <= {24'h00_0000, ctrl_reg};
            else
                rdata_reg <= 32'h0000_0000;
        end
    end

    // Framer-facing parameters; the end character only matters in 8B/10B mode
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            link_reg.serial_link_enable <= 1'b0;
            link_reg.enc_8b10b <= 1'b0;
            link_reg.device_id <= slr_pkg::DEV_ID_RST;
            link_reg.eof_char_valid <= 1'b0;
            link_reg.eof_char <= slr_pkg::K28_7;
        end
        else
        begin
            link_reg.serial_link_enable <= ctrl_reg[slr_pkg::CTRL_ENABLE];
            link_reg.enc_8b10b <= ctrl_reg[slr_pkg::CTRL_ENC_8B10B];
            link_reg.device_id <= dev_id_reg;
            link_reg.eof_char <= eof_code(end_char_reg[1:0]);
            // Reserved code inserts nothing rather than guessing a character
            link_reg.eof_char_valid <= ctrl_reg[slr_pkg::CTRL_ENC_8B10B]
                && end_char_reg[1:0] != 2'b11;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;
    assign link_o = link_reg;
    assign irq_o = irq_reg;
endmodule
`default_nettype wire

// *** test/slr_regs_monitor.sv ***
// Concurrent checks on the link register bank ports.
// Assumes a master that releases its request at the ack edge.
`timescale 1ns/1ps
`default_nettype none
module slr_regs_monitor (
    input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, // Bus, irq
    input wire logic [13:0] wb_adr_i, // Byte address
    input wire logic [3:0] wb_sel_i, // Byte selects
    input wire logic [31:0] wb_dat_i, wb_dat_o, // Data
    input wire slr_pkg::slr_link_in_s link_i, // Status inputs
    input wire slr_pkg::slr_link_out_s link_o // Link parameters
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_wr(logic [13:0] a);
        s_take ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == a);
    endsequence
    sequence s_st_rd;
        wb_ack_o && !wb_we_i && wb_adr_i == 14'h0820;
    endsequence
    property p_id;
        logic [7:0] d;
        (s_wr(14'h0818), d = wb_dat_i[7:0]) |-> ##2 link_o.device_id == d;
    endproperty
    property p_eof;
        logic [1:0] c;
        (s_wr(14'h081C), c = wb_dat_i[1:0]) |-> ##2 c == 2'h3 || link_o.eof_char ==
            (c == 2'h0 ? slr_pkg::K28_7 : c == 2'h1 ? slr_pkg::K28_1 : slr_pkg::K28_5);
    endproperty
    AST_ACK: assert property (s_take |=> wb_ack_o ##1 !wb_ack_o) else $error("bad ack");
    AST_ID: assert property (p_id) else $error("id not sent");
    AST_EOF: assert property (p_eof) else $error("wrong end char");
    AST_LINK: assert property (s_st_rd |-> wb_dat_o[6:5] ==
        $past({link_i.link_up, link_i.sync_req_n}, 2)) else $error("link bits wrong");
    AST_PLL: assert property (s_st_rd |-> {wb_dat_o[2], wb_dat_o[0]} ==
        $past({link_i.serializer_pll_lock, link_i.converter_pll_lock}, 2)) else $error("lock");
    AST_RSVD: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits");
    AST_RST: assert property ($fell(rst_i) |-> link_o.device_id == 8'h00 && !irq_o &&
        link_o.eof_char == slr_pkg::K28_7 && !wb_ack_o) else $error("reset values");
    AST_IRQ: assert property (irq_o && !(wb_cyc_i && wb_we_i) |=> irq_o)
        else $error("event dropped");
endmodule
bind slr_regs slr_regs_monitor mon_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .link_i(link_i), .link_o(link_o));
`default_nettype wire

// *** test/slr_rx_model.sv ***
// Link receiver model: requests sync until the link has been enabled a while.
// Assumes the enable comes straight from the bank's link output.
`timescale 1ns/1ps
`default_nettype none
module slr_rx_model (
    input wire logic clk_i, // Clock
    input wire logic en_i, // Link enable
    output logic sync_n_o, // High once sync request is released
    output logic up_o // Link established
);
    logic [2:0] cnt_reg;
    always_ff @(posedge clk_i)
    begin
        cnt_reg <= !en_i ? 3'h0 : cnt_reg + 3'(cnt_reg != 3'h7);
        sync_n_o <= en_i && cnt_reg > 3'h2;
        up_o <= en_i && cnt_reg > 3'h4;
    end
endmodule
`default_nettype wire

// *** test/test_slr_regs.sv ***
// Self-checking bench: Wishbone master, receiver model and a reference model.
// Assumes the bank answers every request and all inputs share clk_i.
`timescale 1ns/1ps
`default_nettype none
module test_slr_regs;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, we = 1'b0, shf = 1'b0, evt = 1'b0, spll = 1'b0, cpll = 1'b0;
    logic rl = 1'b0, al = 1'b0, ack, irq, sync_n, up;
    logic [3:0] sel = 4'hF;
    logic [7:0] code, msk = 8'h00;
    logic [11:0] adr = 12'h000;
    logic [31:0] wdat = 32'h0, rdat, got;
    logic [7:0] k [4] = '{8'hFC, 8'h3C, 8'hBC, 8'h00};
    logic [11:0] ra [6] = '{12'h206, 12'h207, 12'h208, 12'h20A, 12'h20B, 12'h3F0};
    int errors = 0, cmp_count = 0, seed = 92965;
    slr_pkg::slr_link_in_s lin;
    slr_pkg::slr_link_out_s lout;
    always #4 clk_i = ~clk_i;
    assign lin = {up, sync_n, shf, evt, spll, cpll};
    slr_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i({adr, 2'b00}), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .link_i(lin), .link_o(lout), .irq_o(irq));
    slr_rx_model rx_u (.clk_i(clk_i), .en_i(lout.serial_link_enable), .sync_n_o(sync_n),
        .up_o(up));
    function automatic int xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] est();
        return {1'b0, up, sync_n, rl, al, spll, 1'b0, cpll};
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        cmp_count++;
        if (g !== e)
        begin
            errors++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 50)
        begin
            @(posedge clk_i);
            n++;
        end
        got = rdat;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        chk(got, {24'h0, e}, "read");
    endtask
    // One-cycle pulse on the realign input (0) or the SYSREF event input (1)
    task automatic pulse(input bit ev);
        if (ev)
            evt <= 1'b1;
        else
            shf <= 1'b1;
        @(posedge clk_i);
        evt <= 1'b0;
        shf <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic summarize();
        $display("counts: %0d compares, %0d mismatches", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        #40000;
        errors++;
        summarize();
    end
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (ra[i])
            rd(ra[i], 8'h00);
        chk(lout.eof_char, slr_pkg::K28_7, "eof");
        $display("test reset done");
        wb(1'b1, 12'h20B, 8'h02);
        chk(lout.enc_8b10b, 1'b1, "enc");
        code = 8'(xs());
        wb(1'b1, 12'h206, code);
        chk(lout.device_id, code, "id");
        sel <= 4'h0;
        wb(1'b1, 12'h206, ~code);
        sel <= 4'hF;
        rd(12'h206, code);
        for (int c = 0; c < 4; c++)
        begin
            wb(1'b1, 12'h207, 8'(c));
            rd(12'h207, 8'(c));
            chk(lout.eof_char_valid ? lout.eof_char : 8'h00, k[c], "eof");
        end
        wb(1'b1, 12'h207, 8'h01);
        wb(1'b1, 12'h20B, 8'h00);
        chk(lout.eof_char_valid, 1'b0, "eof valid");
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(12'h206, 8'h00);
        $display("test params done");
        spll <= 1'b1;
        cpll <= 1'(xs());
        wb(1'b1, 12'h20B, 8'h03);
        repeat (12) @(posedge clk_i);
        rd(12'h208, est());
        wb(1'b1, 12'h20A, 8'h08);
        msk = 8'h08;
        pulse(1'b0);
        rl = 1'b1;
        chk(irq, |(est() & msk), "irq");
        wb(1'b1, 12'h20A, 8'h18);
        msk = 8'h18;
        chk(irq, |(est() & msk), "irq");
        wb(1'b1, 12'h208, 8'h65);
        rd(12'h208, est());
        wb(1'b1, 12'h208, 8'h10);
        rl = 1'b0;
        rd(12'h208, est());
        chk(irq, |(est() & msk), "irq");
        pulse(1'b1);
        al = 1'b1;
        rd(12'h208, est());
        wb(1'b1, 12'h208, 8'h08);
        al = 1'b0;
        pulse(1'b1);
        rd(12'h208, est());
        wb(1'b1, 12'h20B, 8'h02);
        wb(1'b1, 12'h20B, 8'h03);
        repeat (12) @(posedge clk_i);
        pulse(1'b1);
        al = 1'b1;
        rd(12'h208, est());
        chk(irq, |(est() & msk), "irq");
        $display("test status done");
        summarize();
    end
endmodule
`default_nettype wire
